// [verilog/ccpw_pkg.sv]
/*
  constants and carrier types of the capture, compare and pulse-width unit.
  assumes a byte-addressed bus where byte address = 4 * register index.
*/
package ccpw_pkg;
  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_MATCH_LOW = 8'h15;
  localparam logic [7:0] IDX_MATCH_HIGH = 8'h16;
  localparam logic [7:0] IDX_CONTROL = 8'h17;
  localparam logic [7:0] IDX_STATUS = 8'h18;
  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_DUTY_LSB = 4;
  localparam int STAT_FLAG_BIT = 2;
  localparam int STAT_LATCH_BIT = 7;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] DUTY_BITS_RESET = 2'h0;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  // ----------------------------------------------------------------------
  // mode encodings and prescaler terminal counts
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [3:0] PRESC_LAST_4 = 4'h3;
  localparam logic [3:0] PRESC_LAST_16 = 4'hf;

  // timer and converter view seen by the unit
  typedef struct packed {
    logic [15:0] first_timer_count;
    logic first_timer_tick;
    logic [7:0] second_timer_count;
    logic [7:0] second_timer_period;
    logic second_timer_tick;
    logic [1:0] second_timer_sub;
    logic adc_enabled;
  } ccpw_timers_t;
endpackage

// [verilog/ccpw_unit.sv]
/*
  capture, compare and pulse-width unit with an avalon-mm register slave.
  assumes timers and converter sit outside and run on ref_clk; pins async.
*/
// Register access over Avalon-MM was chosen for this implementation.
// What the document asks of this block and its software
// RQ1: mode zero disables and resets the unit
// RQ2: capture modes pick falling, rising, 4th, 16th
// RQ3: capture copies first timer into value
// RQ4: capture sets flag; only software clears it
// RQ5: newer capture overwrites unread earlier value
// RQ6: prescaler held clear outside capture mode
// RQ7: capture prescaler switch keeps counter value
// RQ8: software clears control before new prescaler
// RQ9: software masks interrupt while changing mode
// RQ10: compare value with first timer each update
// RQ11: match sets or clears pin, sets flag
// RQ12: soft mode match sets flag only
// RQ13: trigger mode clears timer, starts conversion
// RQ14: trigger clear never sets timer overflow flag
// RQ15: zero control write forces output latch low
// RQ16: modes 11xx give ten-bit pulse width
// RQ17: control bits 5-4 are duty low bits
// RQ18: first timer for capture/compare, second pwm
// RQ19: software runs first timer synchronously
// RQ20: capture sees pin level whatever direction
// RQ21: pin routed to port pin zero or three
// RQ22: value seen as two byte registers
// RQ23: period end clears timer, sets pin, reloads
// RQ24: pin clears when duty equals extended timer
// RQ25: high byte read-only in pulse-width mode
// RQ26: pin passes two flip-flops before edges
// RQ27: prescaler counter clears on each capture
`timescale 1ns/10ps
module ccpw_unit #(
  parameter int ADDR_W = 7
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ccpw_pkg::ccpw_timers_t timers,
  input wire logic pin_route_select,
  input wire logic port_pin_zero_in,
  input wire logic port_pin_three_in,
  output logic port_pin_zero_out,
  output logic port_pin_zero_oe_n,
  output logic port_pin_three_out,
  output logic port_pin_three_oe_n,
  output logic unit_irq_flag,
  output logic first_timer_clear,
  output logic adc_start
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] match_value_low;
  logic [7:0] match_value_high;
  logic [3:0] unit_mode_select;
  logic [1:0] duty_lsb;
  logic [1:0] duty_latch;
  logic [3:0] presc_cnt;
  logic out_latch;
  logic route_s1;
  logic route_s2;
  logic zero_s1;
  logic zero_s2;
  logic three_s1;
  logic three_s2;
  logic pin_prev;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire logic req = avs_read | avs_write;
  wire logic take = req & ~avs_waitrequest;
  wire logic wr = avs_write & take;
  wire logic [ADDR_W-1:0] a_low =
    ADDR_W'({ccpw_pkg::IDX_MATCH_LOW, 2'b00});
  wire logic [ADDR_W-1:0] a_high =
    ADDR_W'({ccpw_pkg::IDX_MATCH_HIGH, 2'b00});
  wire logic [ADDR_W-1:0] a_ctrl =
    ADDR_W'({ccpw_pkg::IDX_CONTROL, 2'b00});
  wire logic [ADDR_W-1:0] a_stat =
    ADDR_W'({ccpw_pkg::IDX_STATUS, 2'b00});
  wire logic sel_low = avs_address == a_low;
  wire logic sel_high = avs_address == a_high;
  wire logic sel_ctrl = avs_address == a_ctrl;
  wire logic sel_stat = avs_address == a_stat;
  wire logic wr_low = wr & sel_low;
  wire logic wr_high = wr & sel_high;
  wire logic wr_ctrl = wr & sel_ctrl;
  wire logic wr_stat = wr & sel_stat;
  wire logic flag_clr = wr_stat & avs_writedata[ccpw_pkg::STAT_FLAG_BIT];
  logic [7:0] rd_mux;
  always_comb begin
    if (sel_low) begin
      rd_mux = match_value_low;
    end else if (sel_high) begin
      rd_mux = match_value_high;
    end else if (sel_ctrl) begin
      rd_mux = {2'b00, duty_lsb, unit_mode_select};
    end else if (sel_stat) begin
      rd_mux = 8'h00;
      rd_mux[ccpw_pkg::STAT_FLAG_BIT] = unit_irq_flag;
      rd_mux[ccpw_pkg::STAT_LATCH_BIT] = out_latch;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  wire logic mode_off = unit_mode_select == ccpw_pkg::MODE_RESET; // RQ1
  wire logic is_cap = unit_mode_select[3:2] == 2'b01;
  wire logic is_cmp = unit_mode_select[3:2] == 2'b10;
  wire logic is_pwm = unit_mode_select[3:2] == ccpw_pkg::MODE_PWM_TOP; // RQ16

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      route_s1 <= 1'b0;
      route_s2 <= 1'b0;
      zero_s1 <= 1'b0;
      zero_s2 <= 1'b0;
      three_s1 <= 1'b0;
      three_s2 <= 1'b0;
    end else begin
      route_s1 <= pin_route_select;
      route_s2 <= route_s1;
      zero_s1 <= port_pin_zero_in; // RQ26
      zero_s2 <= zero_s1;
      three_s1 <= port_pin_three_in;
      three_s2 <= three_s1;
    end
  end
  // pad level, whatever the port direction
  wire logic pin_level = route_s2 ? zero_s2 : three_s2; // RQ20 RQ21
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_level;
    end
  end
  wire logic rise = pin_level & ~pin_prev;
  wire logic fall = ~pin_level & pin_prev;

  // ----------------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------------
  wire logic cap_fall = unit_mode_select == ccpw_pkg::MODE_CAP_FALL;
  wire logic cap_rise = unit_mode_select == ccpw_pkg::MODE_CAP_RISE;
  wire logic cap_4th = unit_mode_select == ccpw_pkg::MODE_CAP_4TH;
  wire logic cap_16th = unit_mode_select == ccpw_pkg::MODE_CAP_16TH;
  wire logic presc_hit4 = presc_cnt == ccpw_pkg::PRESC_LAST_4;
  wire logic presc_hit16 = presc_cnt == ccpw_pkg::PRESC_LAST_16;
  wire logic cap_evt = (cap_fall & fall) | (cap_rise & rise) |
                       (cap_4th & rise & presc_hit4) |
                       (cap_16th & rise & presc_hit16); // RQ2
  wire logic [3:0] presc_inc = presc_cnt + 4'h1;
  logic [3:0] next_presc;
  always_comb begin
    if (!is_cap) begin
      next_presc = 4'h0; // RQ6
    end else if (cap_evt) begin
      next_presc = 4'h0; // RQ27
    end else if (rise & (cap_4th | cap_16th)) begin
      next_presc = presc_inc; // RQ7
    end else begin
      next_presc = presc_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------------
  wire logic [15:0] match_value = {match_value_high, match_value_low};
  wire logic cmp_hit = is_cmp & timers.first_timer_tick &
    (timers.first_timer_count == match_value); // RQ10 RQ18
  wire logic cmp_trig =
    cmp_hit & (unit_mode_select == ccpw_pkg::MODE_CMP_TRIG);

  // ----------------------------------------------------------------------
  // pulse width
  // ----------------------------------------------------------------------
  wire logic [9:0] duty_new = {match_value_low, duty_lsb}; // RQ17
  wire logic pwm_reload = is_pwm & timers.second_timer_tick &
    (timers.second_timer_count == timers.second_timer_period); // RQ23
  // clear lands as the extended timer reaches the duty value
  wire logic [9:0] pwm_pos_next =
    {timers.second_timer_count, timers.second_timer_sub} + 10'h001;
  wire logic pwm_clear = is_pwm &
    ({match_value_high, duty_latch} == pwm_pos_next); // RQ24

  // ----------------------------------------------------------------------
  // output latch
  // ----------------------------------------------------------------------
  logic next_latch;
  always_comb begin
    if (mode_off) begin
      next_latch = 1'b0; // RQ15
    end else if (cmp_hit &
                 unit_mode_select == ccpw_pkg::MODE_CMP_SET) begin
      next_latch = 1'b1; // RQ11
    end else if (cmp_hit &
                 unit_mode_select == ccpw_pkg::MODE_CMP_CLR) begin
      next_latch = 1'b0; // RQ11
    end else if (pwm_reload) begin
      next_latch = duty_new != 10'h000; // RQ23
    end else if (pwm_clear) begin
      next_latch = 1'b0; // RQ24
    end else begin
      next_latch = out_latch; // RQ12
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unit_mode_select <= ccpw_pkg::MODE_RESET;
      duty_lsb <= ccpw_pkg::DUTY_BITS_RESET;
    end else if (wr_ctrl) begin
      unit_mode_select <= avs_writedata[3:0];
      duty_lsb <= avs_writedata[ccpw_pkg::CTRL_DUTY_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      match_value_low <= ccpw_pkg::MATCH_RESET;
    end else if (is_cap & cap_evt) begin
      match_value_low <= timers.first_timer_count[7:0]; // RQ3 RQ5
    end else if (wr_low) begin
      match_value_low <= avs_writedata[7:0]; // RQ22
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      match_value_high <= ccpw_pkg::MATCH_RESET;
    end else if (is_cap & cap_evt) begin
      match_value_high <= timers.first_timer_count[15:8]; // RQ3 RQ5
    end else if (pwm_reload) begin
      match_value_high <= match_value_low; // RQ23
    end else if (wr_high & ~is_pwm) begin
      match_value_high <= avs_writedata[7:0]; // RQ22 RQ25
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst | mode_off) begin
      duty_latch <= 2'h0; // RQ1
      presc_cnt <= 4'h0;
      out_latch <= 1'b0;
    end else begin
      if (pwm_reload) begin
        duty_latch <= duty_lsb;
      end
      presc_cnt <= next_presc;
      out_latch <= next_latch;
    end
  end

  // set wins over a software clear in the same cycle
  wire logic flag_set = cap_evt | cmp_hit; // RQ4 RQ11 RQ12 RQ13
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unit_irq_flag <= 1'b0;
    end else if (flag_set) begin
      unit_irq_flag <= 1'b1;
    end else if (flag_clr) begin
      unit_irq_flag <= 1'b0;
    end
  end

  // trigger clears the timer and, with the converter enabled, starts a conversion; no overflow indication
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      first_timer_clear <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      first_timer_clear <= cmp_trig; // RQ13 RQ14
      adc_start <= cmp_trig & timers.adc_enabled; // RQ13
    end
  end

  // pin drive follows the latch on the routed pin
  wire logic drives = is_cmp | is_pwm;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port_pin_zero_out <= 1'b0;
      port_pin_zero_oe_n <= 1'b1;
      port_pin_three_out <= 1'b0;
      port_pin_three_oe_n <= 1'b1;
    end else begin
      port_pin_zero_out <= route_s2 & next_latch; // RQ21
      port_pin_zero_oe_n <= ~(route_s2 & drives);
      port_pin_three_out <= ~route_s2 & next_latch;
      port_pin_three_oe_n <= ~(~route_s2 & drives);
    end
  end

  // bus answer one cycle after the request is seen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_OFF_RESET: assert property ( // RQ1
    mode_off |=> (presc_cnt == 4'h0) && !out_latch && duty_latch == 2'h0)
    else $error("unit not held reset while off");
  AST_FALL_ONLY: assert property ( // RQ2
    cap_fall && rise |-> !cap_evt)
    else $error("rising edge captured in falling mode");
  AST_CAP_VALUE: assert property ( // RQ3
    cap_evt |=> match_value == $past(timers.first_timer_count))
    else $error("capture did not copy the timer");
  AST_CAP_FLAG: assert property ( // RQ4
    cap_evt |=> unit_irq_flag)
    else $error("capture did not set the flag");
  AST_PRESC_IDLE: assert property ( // RQ6
    !is_cap |=> presc_cnt == 4'h0)
    else $error("prescaler not clear outside capture");
  AST_CMP_SET: assert property ( // RQ11
    cmp_hit && unit_mode_select == ccpw_pkg::MODE_CMP_SET
    |=> out_latch && unit_irq_flag)
    else $error("set-on-match failed");
  AST_CMP_CLR: assert property ( // RQ11
    cmp_hit && unit_mode_select == ccpw_pkg::MODE_CMP_CLR
    |=> !out_latch && unit_irq_flag)
    else $error("clear-on-match failed");
  AST_SOFT_PIN: assert property ( // RQ12
    cmp_hit && unit_mode_select == ccpw_pkg::MODE_CMP_SOFT
    |=> $stable(out_latch))
    else $error("soft mode moved the pin");
  AST_TRIG_PULSE: assert property ( // RQ13
    cmp_trig |=> first_timer_clear ##1 !first_timer_clear)
    else $error("trigger not a single pulse");
  AST_HIGH_RO: assert property ( // RQ25
    is_pwm && wr_high && !pwm_reload |=> $stable(match_value_high))
    else $error("high byte written in pwm mode");
  AST_PWM_SET: assert property ( // RQ23
    pwm_reload && duty_new != 10'h000 |=> out_latch
    && match_value_high == $past(match_value_low))
    else $error("period end did not set and reload");

  COV_CAPTURE: cover property (cap_16th && cap_evt);
  COV_TRIGGER: cover property (cmp_trig && timers.adc_enabled);
  COV_PWM_CYCLE: cover property (pwm_reload ##[1:600] pwm_clear);
  COV_SET_WINS: cover property (flag_set && flag_clr);
endmodule

// [verif/ccpw_pad_model.sv]
/*
  far-side model: a signal source or load on one unit pin.
  assumes the bench sets the source level right after a rising edge.
*/
`timescale 1ns/10ps
module ccpw_pad_model (
  input wire logic src_level,
  input wire logic unit_out,
  input wire logic unit_oe_n,
  output logic pad
);
  // ----------------------------------------------------------------------
  // wire level
  // ----------------------------------------------------------------------
  // source drives while the unit lets go, unit wins while it drives
  assign pad = unit_oe_n ? src_level : unit_out;
endmodule

// [verif/testbench.sv]
/*
  self-checking bench of the capture, compare and pulse-width unit.
  assumes the unit answers the avalon-mm bus and watches the bench timers.
*/
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] L = ccpw_pkg::IDX_MATCH_LOW;
  localparam logic [7:0] H = ccpw_pkg::IDX_MATCH_HIGH;
  localparam logic [7:0] C = ccpw_pkg::IDX_CONTROL;
  localparam logic [7:0] S = ccpw_pkg::IDX_STATUS;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ccpw_pkg::ccpw_timers_t timers;
  logic route = 1'b1;
  logic src0 = 1'b0;
  logic src3 = 1'b0;
  logic pad0, pad3, out0, oe0_n, out3, oe3_n, irq, t1_clr, adc_go;
  logic [15:0] t1 = 16'h0000;
  logic t1_run = 1'b0;
  logic [15:0] t1_nv = 16'h0000;
  logic t1_tog = 1'b0;
  logic t1_seen = 1'b0;
  logic [7:0] t2 = 8'h00;
  logic [1:0] sub = 2'h0;
  logic adc_en = 1'b0;
  int fails = 0;
  int checks_done = 0;
  int n_clr = 0;
  int n_adc = 0;
  logic [7:0] p_low [4] = '{8'h02, 8'h01, 8'h00, 8'h10};
  logic [1:0] p_bits [4] = '{2'h0, 2'h2, 2'h0, 2'h0};
  int p_high [4] = '{32, 24, 0, 64};

  // ----------------------------------------------------------------------
  // clock, timers, design and pads
  // ----------------------------------------------------------------------
  initial forever #2.5 ref_clk = ~ref_clk;
  assign timers = {t1, t1_run, t2, 8'h03, sub == 2'h3, sub, adc_en};
  always @(posedge ref_clk) begin
    sub <= sub + 2'h1;
    if (sub == 2'h3) t2 <= (t2 == 8'h03) ? 8'h00 : t2 + 8'h01;
    t1_seen <= t1_tog;
    if (t1_clr === 1'b1) t1 <= 16'h0000;
    else if (t1_tog != t1_seen) t1 <= t1_nv;
    else if (t1_run) t1 <= t1 + 16'h0001;
    if (t1_clr === 1'b1) n_clr <= n_clr + 1;
    if (adc_go === 1'b1) n_adc <= n_adc + 1;
  end
  ccpw_unit dut (.ref_clk(ref_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timers(timers), .pin_route_select(route),
    .port_pin_zero_in(pad0), .port_pin_three_in(pad3),
    .port_pin_zero_out(out0), .port_pin_zero_oe_n(oe0_n),
    .port_pin_three_out(out3), .port_pin_three_oe_n(oe3_n),
    .unit_irq_flag(irq), .first_timer_clear(t1_clr), .adc_start(adc_go));
  ccpw_pad_model pm0 (.src_level(src0), .unit_out(out0),
    .unit_oe_n(oe0_n), .pad(pad0));
  ccpw_pad_model pm3 (.src_level(src3), .unit_out(out3),
    .unit_oe_n(oe3_n), .pad(pad3));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic is_wr, logic [7:0] idx, logic [7:0] wd,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avs_address <= {idx[4:0], 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= is_wr;
    avs_read <= ~is_wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic load_t1(logic [15:0] v);
    t1_nv <= v;
    t1_tog <= ~t1_tog;
  endtask
  task automatic rc(string what, logic [7:0] idx, logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(what, q, exp);
  endtask
  task automatic edge_in(logic lvl);
    @(posedge ref_clk);
    src0 <= lvl;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (irq !== 1'b1 && n < 2000);
    if (irq !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic presc(logic [7:0] mode, int cnt, int pre);
    wr(C, mode);
    repeat (pre) begin
      edge_in(1'b0);
      edge_in(1'b1);
    end
    wr(C, 8'h00);
    wr(C, mode);
    wr(S, 8'h04);
    for (int i = 1; i <= 2 * cnt; i++) begin
      edge_in(1'b0);
      edge_in(1'b1);
      check("prescaled flag", irq, (i % cnt) == 0);
      if (i % cnt == 0) wr(S, 8'h04);
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int c0, a0, h;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    check("pin zero enable", oe0_n, 1);
    rc("control", C, 0);
    rc("status", S, 0);
    rc("unmapped", 8'h00, 0);
    rc("match low", L, 0);
    $display("test reset ended");
    load_t1(16'h1234);
    wr(C, ccpw_pkg::MODE_CAP_RISE);
    wr(S, 8'h04);
    edge_in(1'b1);
    repeat (20) @(posedge ref_clk);
    check("capture flag", irq, 1);
    rc("status", S, 32'h04);
    rc("capture low", L, 32'h34);
    rc("capture high", H, 32'h12);
    edge_in(1'b0);
    load_t1(16'h5678);
    edge_in(1'b1);
    load_t1(16'habcd);
    edge_in(1'b0);
    edge_in(1'b1);
    rc("overwrite low", L, 32'hcd);
    rc("overwrite high", H, 32'hab);
    wr(S, 8'h04);
    @(posedge ref_clk);
    check("flag cleared", irq, 0);
    wr(C, 8'h00);
    wr(C, ccpw_pkg::MODE_CAP_FALL);
    wr(S, 8'h04);
    load_t1(16'h0042);
    edge_in(1'b0);
    check("falling flag", irq, 1);
    rc("falling low", L, 32'h42);
    wr(S, 8'h04);
    edge_in(1'b1);
    check("rise ignored", irq, 0);
    presc(ccpw_pkg::MODE_CAP_4TH, 4, 2);
    presc(ccpw_pkg::MODE_CAP_16TH, 16, 0);
    $display("test capture ended");
    wr(C, 8'h00);
    t1_run <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      route <= r[0];
      wr(L, 8'h40);
      wr(H, 8'h00);
      wr(C, ccpw_pkg::MODE_CMP_SET);
      wr(S, 8'h04);
      load_t1(16'h0000);
      wait_irq();
      check("set pin", r ? out0 : out3, 1);
      check("drive", r ? oe0_n : oe3_n, 0);
      check("other pin", r ? oe3_n : oe0_n, 1);
      wr(C, ccpw_pkg::MODE_CMP_SOFT);
      wr(S, 8'h04);
      load_t1(16'h0000);
      wait_irq();
      check("soft pin", r ? out0 : out3, 1);
      wr(C, ccpw_pkg::MODE_CMP_CLR);
      wr(S, 8'h04);
      load_t1(16'h0000);
      wait_irq();
      check("clear pin", r ? out0 : out3, 0);
    end
    c0 = n_clr;
    a0 = n_adc;
    adc_en <= 1'b1;
    wr(C, ccpw_pkg::MODE_CMP_TRIG);
    wr(S, 8'h04);
    load_t1(16'h0000);
    wait_irq();
    repeat (3) @(posedge ref_clk);
    check("timer clears", n_clr - c0, 1);
    check("conversions", n_adc - a0, 1);
    check("timer restarted", t1 < 16'h0010, 1);
    adc_en <= 1'b0;
    wr(S, 8'h04);
    wait_irq();
    repeat (3) @(posedge ref_clk);
    check("timer clears", n_clr - c0, 2);
    check("no conversion", n_adc - a0, 1);
    wr(C, ccpw_pkg::MODE_CMP_SET);
    wr(S, 8'h04);
    load_t1(16'h0000);
    wait_irq();
    check("latch set", out0, 1);
    t1_run <= 1'b0;
    wr(C, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("latch low", out0, 0);
    $display("test compare ended");
    route <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(L, p_low[k]);
      wr(C, {2'b00, p_bits[k], 2'b11, k[1:0]});
      repeat (40) @(posedge ref_clk);
      h = 0;
      repeat (64) begin
        @(posedge ref_clk);
        if (out0 === 1'b1) h++;
      end
      check("pwm high", h, p_high[k]);
      check("pwm drive", oe0_n, 0);
      rc("duty copy", H, p_low[k]);
      wr(H, 8'h77);
      rc("high locked", H, p_low[k]);
    end
    wr(C, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("pwm latch low", out0, 0);
    check("pin released", oe0_n, 1);
    $display("test pwm ended");
    finish_test();
  end
endmodule
